// ==== design/flbe_regs.svh ====
// Purpose : Constants for the binary-log / log-epsilon datapath
// Assumes : Included by the package and by every design file
// Notes   : Flag positions, fixed point constants, format constants
`ifndef FLBE_REGS_SVH
`define FLBE_REGS_SVH

// -----------------------------------------------------------------
// Exception flag positions and reset values
// -----------------------------------------------------------------
`define FLBE_F_OVF      0
`define FLBE_F_UNF      1
`define FLBE_F_INV      2
`define FLBE_F_ZDV      3
`define FLBE_F_INX      4
`define FLBE_NFLAGS     5
`define FLBE_RST_FLAGS  5'h00

// -----------------------------------------------------------------
// Log iteration: fraction bits, Q2.60 constants
// -----------------------------------------------------------------
`define FLBE_LOG_FB     58
`define FLBE_LOG_ONE    59'h400000000000000
`define FLBE_Q_ONE      64'h1000000000000000
`define FLBE_Q_TWO      64'h2000000000000000
`define FLBE_Q_RT2      64'h16A09E667F3BCC90
`define FLBE_Q_IRT2     64'h0B504F333F9DE648

// -----------------------------------------------------------------
// Real (single) and long-real (double) format constants
// -----------------------------------------------------------------
`define FLBE_BIAS_L     1023
`define FLBE_BIAS_S     127
`define FLBE_EOFS_L     1075
`define FLBE_EOFS_S     179
`define FLBE_EMAX_L     2047
`define FLBE_EMAX_S     255
`define FLBE_FW_L       52
`define FLBE_FW_S       23
`define FLBE_QNAN_L     64'h7FF8000000000000
`define FLBE_QNAN_S     64'h000000007FC00000
`define FLBE_INF_L      64'h7FF0000000000000
`define FLBE_INF_S      64'h000000007F800000
`define FLBE_SGN_L      64'h8000000000000000
`define FLBE_SGN_S      64'h0000000080000000
// Clamped minimum exponent as a negative real; denormals must go below
`define FLBE_LOGB_MIN_L 64'hC08FF00000000000
`define FLBE_LOGB_MIN_S 64'h00000000C2FC0000

`endif

// ==== design/flbe_pkg.sv ====
// Purpose : Types shared by the log datapath files
// Assumes : flbe_regs.svh supplies the widths
// Notes   : Nothing here holds state
`include "flbe_regs.svh"

package flbe_pkg;

   // Operation select
   typedef enum logic {
      FLBE_OP_LOGB  = 1'h0,
      FLBE_OP_LOGEP = 1'h1
   } flbe_op_e;

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      FLBE_ST_IDLE = 5'h01,
      FLBE_ST_PREP = 5'h02,
      FLBE_ST_LOG  = 5'h04,
      FLBE_ST_PACK = 5'h08,
      FLBE_ST_DONE = 5'h10
   } flbe_state_e;

   // Unpacked operand: value = m * 2^e
   typedef struct packed {
      logic               sgn;
      logic               zero;
      logic               den;
      logic               inf;
      logic               nan;
      logic               snan;
      logic [52:0]        m;
      logic signed [13:0] e;
   } flbe_unp_s;

   // State of the top sequencer
   typedef struct packed {
      flbe_state_e                st;
      flbe_op_e                   op;
      logic                       lng;
      logic [63:0]                a;
      logic [63:0]                b;
      logic [63:0]                y;
      logic                       go;
      logic                       sgn;
      logic [127:0]               mag;
      logic signed [13:0]         e;
      logic [`FLBE_NFLAGS-1:0]    flags;
      logic                       fault;
      logic                       rsv;
      logic [63:0]                res;
   } flbe_main_s;

   // State of the log iteration core
   typedef struct packed {
      logic                       busy;
      logic                       done;
      logic [5:0]                 cnt;
      logic [63:0]                y;
      logic [`FLBE_LOG_FB-1:0]    f;
      logic                       neg;
   } flbe_core_s;

endpackage : flbe_pkg

// ==== design/flbe_log_if.sv ====
// Purpose : Link between the sequencer and the log iteration core
// Assumes : One clock, driven by the top module
// Notes   : go is a one-cycle pulse, done likewise
`timescale 1ns/1ps
`include "flbe_regs.svh"

interface flbe_log_if;
   logic                      go;    // Start pulse
   logic [63:0]               y;     // Argument, Q2.60
   logic                      done;  // Result ready pulse
   logic [`FLBE_LOG_FB-1:0]   frac;  // Fraction bits of log2
   logic                      neg;   // Integral part is -1

   modport core (input go, input y, output done, output frac,
                 output neg);
   modport user (output go, output y, input done, input frac,
                 input neg);
endinterface : flbe_log_if

// ==== design/flbe_log2.sv ====
// Purpose : Bit-serial log2 of an argument near one
// Assumes : Argument lies between 1/sqrt2 and sqrt2 in Q2.60
// Notes   : One fraction bit per cycle by repeated squaring
`timescale 1ns/1ps
`include "flbe_regs.svh"

module flbe_log2 (
   input  wire logic   clk_i,    // Clock
   input  wire logic   rst_n_i,  // Synchronised reset, active low
   flbe_log_if.core    lg        // Link to the sequencer
);

   flbe_pkg::flbe_core_s q;
   flbe_pkg::flbe_core_s d;
   logic [127:0]         sq;
   logic [63:0]          ysq;

   // -----------------------------------------------------------------
   // Iteration
   // -----------------------------------------------------------------
   // Squaring doubles the log; a carry past two gives a one bit
   always_comb begin
      d      = q;
      d.done = 1'h0;
      sq     = q.y * q.y;
      ysq    = sq[123:60];
      if (lg.go) begin
         d.busy = 1'h1;
         d.cnt  = 6'h00;
         d.f    = '0;
         // Below one: double it and remember an integral part of -1
         if (lg.y < `FLBE_Q_ONE) begin
            d.y   = {lg.y[62:0], 1'h0};
            d.neg = 1'h1;
         end else begin
            d.y   = lg.y;
            d.neg = 1'h0;
         end
      end else if (q.busy) begin
         if (ysq >= `FLBE_Q_TWO) begin
            d.y = {1'h0, ysq[63:1]};
            d.f = {q.f[`FLBE_LOG_FB-2:0], 1'h1};
         end else begin
            d.y = ysq;
            d.f = {q.f[`FLBE_LOG_FB-2:0], 1'h0};
         end
         d.cnt = q.cnt + 6'h01;
         if (q.cnt == 6'(`FLBE_LOG_FB - 1)) begin
            d.busy = 1'h0;
            d.done = 1'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lg.done = q.done;
   assign lg.frac = q.f;
   assign lg.neg  = q.neg;

   // Fixed latency lets the sequencer bound its wait
   lg_latency_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      lg.go |-> ##59 lg.done)
      else $error("log core latency wrong");

endmodule : flbe_log2

// ==== design/flbe_unit.sv ====
// Purpose : Binary-log and log-epsilon floating datapath
// Assumes : Operands stable only at start; long forms use 64 bits
// Notes   : Single forms use the low 32 bits of each operand
`timescale 1ns/1ps
`include "flbe_regs.svh"

module flbe_unit (
   input  wire logic                    clk_i,          // 50 MHz
   input  wire logic                    arst_n_i,       // Async reset
   input  wire logic                    start_i,        // Issue pulse
   input  wire logic                    op_i,           // 1: log-eps
   input  wire logic                    long_i,         // 1: long real
   input  wire logic [63:0]             src1_i,         // Source 1
   input  wire logic [63:0]             src2_i,         // Source 2
   input  wire logic [`FLBE_NFLAGS-1:0] ac_mask_i,      // 1 = masked
   input  wire logic                    ac_norm_mode_i, // Normalizing
   output logic                         busy_o,         // Working
   output logic                         done_o,         // Result pulse
   output logic [63:0]                  res_o,          // Result
   output logic [`FLBE_NFLAGS-1:0]      flags_o,        // Exceptions
   output logic                         fault_o,        // Unmasked exc
   output logic                         rsv_fault_o     // Reserved enc
);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic flbe_pkg::flbe_unp_s unpack(
      input logic [63:0] x, input logic lng);
      flbe_pkg::flbe_unp_s u;
      logic [10:0]         ef;
      logic [51:0]         fr;
      logic [10:0]         em;
      ef = lng ? x[62:52] : {3'h0, x[30:23]};
      fr = lng ? x[51:0] : {x[22:0], 29'h0};
      em = lng ? 11'h7FF : 11'h0FF;
      u.sgn  = lng ? x[63] : x[31];
      u.zero = (ef == 11'h000) && (fr == 52'h0);
      u.den  = (ef == 11'h000) && (fr != 52'h0);
      u.inf  = (ef == em) && (fr == 52'h0);
      u.nan  = (ef == em) && (fr != 52'h0);
      u.snan = u.nan && !fr[51];
      u.m    = {ef != 11'h000, fr};
      u.e    = 14'(int'((ef == 11'h000) ? 11'h001 : ef)
                  - (lng ? `FLBE_EOFS_L : `FLBE_EOFS_S));
      return u;
   endfunction : unpack

   // Position of the leading one of a significand
   function automatic int lead(input logic [52:0] m);
      int p;
      p = 0;
      for (int i = 0; i < 53; i++) begin
         if (m[i]) begin
            p = i;
         end
      end
      return p;
   endfunction : lead

   // Round to nearest even; returns {tiny, ovf, inexact, bits}
   function automatic logic [66:0] pack(input logic s,
      input logic [127:0] m, input logic signed [13:0] e,
      input logic lng);
      int           p;
      int           be;
      int           sh;
      int           fw;
      logic [127:0] n;
      logic [127:0] nn;
      logic [52:0]  sig;
      logic         rb;
      logic         st;
      logic         ovf;
      logic         tiny;
      logic [63:0]  sum;
      logic [63:0]  res;
      p = 0;
      for (int i = 0; i < 128; i++) begin
         if (m[i]) begin
            p = i;
         end
      end
      fw = lng ? `FLBE_FW_L : `FLBE_FW_S;
      be = int'(e) + p + (lng ? `FLBE_BIAS_L : `FLBE_BIAS_S);
      sh = (be < 1) ? 1 - be : 0;
      if (sh > 128) begin
         sh = 128;
      end
      n  = m << (127 - p);
      // Denormal results: shift right, fold lost bits into sticky
      n  = (n >> sh) | {127'h0, |(n & ~({128{1'h1}} << sh))};
      nn = lng ? n : {29'h0, n[127:29]};
      sig = nn[127:75];
      rb  = nn[74];
      st  = (|nn[73:0]) | (!lng && (|n[28:0]));
      // Carry out of the significand bumps the exponent for free
      sum = (64'((sh > 0) ? 0 : be - 1) << fw) + 64'(sig)
            + 64'(rb && (st || sig[0]));
      ovf  = (sum >> fw) >= 64'(lng ? `FLBE_EMAX_L : `FLBE_EMAX_S);
      tiny = sh > 0;
      res  = ovf ? (lng ? `FLBE_INF_L : `FLBE_INF_S) : sum;
      if (m == 128'h0) begin
         res  = 64'h0;
         ovf  = 1'h0;
         tiny = 1'h0;
         rb   = 1'h0;
         st   = 1'h0;
      end
      res = res | (s ? (lng ? `FLBE_SGN_L : `FLBE_SGN_S) : 64'h0);
      return {tiny, ovf, rb | st, res};
   endfunction : pack

   // -----------------------------------------------------------------
   // Reset release and state
   // -----------------------------------------------------------------
   logic [1:0]          rst_sync_q;
   logic                rst_n;
   flbe_pkg::flbe_main_s q;
   flbe_pkg::flbe_main_s d;
   flbe_pkg::flbe_unp_s  ua;
   flbe_pkg::flbe_unp_s  ub;
   flbe_pkg::flbe_unp_s  ur;
   logic [116:0]        x_wide;
   logic [63:0]         y_fix;
   logic                a_big;
   logic                in_rng;
   logic                is_ep;
   logic [58:0]         lmag;
   logic [66:0]         pk;
   logic [63:0]         qnan;
   logic [63:0]         inf;
   int                  sh1;
   int                  k;
   flbe_log_if          lg ();

   // Release through two flops so no flop sees a ragged edge
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'h1};
      end
   end
   assign rst_n = rst_sync_q[1];

   flbe_log2 u_log (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .lg      (lg)
   );
   assign lg.go = q.go;
   assign lg.y  = q.y;

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   // Long operands arrive as {odd, even} register pair
   always_comb begin
      d    = q;
      d.go = 1'h0;
      ua   = unpack(q.a, q.lng);
      ub   = unpack(q.b, q.lng);
      is_ep = q.op == flbe_pkg::FLBE_OP_LOGEP;
      qnan = q.lng ? `FLBE_QNAN_L : `FLBE_QNAN_S;
      inf  = q.lng ? `FLBE_INF_L : `FLBE_INF_S;
      // src1 into Q2.60, then src1 + 1 checked against the window
      sh1 = 4 - int'(ua.e);
      if (sh1 < 0) begin
         sh1 = 0;
      end
      x_wide = {ua.m, 64'h0} >> sh1;
      y_fix  = ua.sgn ? `FLBE_Q_ONE - x_wide[63:0]
                      : `FLBE_Q_ONE + x_wide[63:0];
      a_big  = ua.inf || (!ua.nan && !ua.zero
                          && (lead(ua.m) + int'(ua.e) >= 0));
      in_rng = !a_big && (y_fix >= `FLBE_Q_IRT2)
               && (y_fix <= `FLBE_Q_RT2);
      lmag = lg.neg ? `FLBE_LOG_ONE - {1'h0, lg.frac}
                    : {1'h0, lg.frac};
      k  = lead(ua.m) + int'(ua.e);
      pk = pack(q.sgn, q.mag, q.e, q.lng);
      case (q.st)
         flbe_pkg::FLBE_ST_IDLE: begin
            if (start_i) begin
               d.st    = flbe_pkg::FLBE_ST_PREP;
               d.op    = flbe_pkg::flbe_op_e'(op_i);
               d.lng   = long_i;
               d.a     = src1_i;
               d.b     = src2_i;
               d.flags = `FLBE_RST_FLAGS;
               d.rsv   = 1'h0;
               d.fault = 1'h0;
            end
         end
         flbe_pkg::FLBE_ST_PREP: begin
            d.st = flbe_pkg::FLBE_ST_DONE;
            if (ac_norm_mode_i && (ua.den || (is_ep && ub.den))) begin
               d.rsv = 1'h1;
            end else if (ua.nan || (is_ep && ub.nan)) begin
               d.res = qnan;
               d.flags[`FLBE_F_INV] = ua.snan
                                      || (is_ep && ub.snan);
            end else if (!is_ep) begin
               if (ua.inf) begin
                  d.res = inf;
               end else if (ua.zero) begin
                  d.res = inf | (q.lng ? `FLBE_SGN_L : `FLBE_SGN_S);
                  d.flags[`FLBE_F_ZDV] = 1'h1;
               end else begin
                  // Exact integer; denormals keep their true exponent
                  d.sgn = k < 0;
                  d.mag = 128'((k < 0) ? -k : k);
                  d.e   = 14'h0000;
                  d.st  = flbe_pkg::FLBE_ST_PACK;
               end
            end else if (!in_rng || (ua.zero && ub.inf)) begin
               d.res = qnan;
               d.flags[`FLBE_F_INV] = 1'h1;
            end else if (ua.zero || ub.zero) begin
               d.res = ((ua.sgn ^ ub.sgn)
                        ? (q.lng ? `FLBE_SGN_L : `FLBE_SGN_S) : 64'h0);
            end else if (ub.inf) begin
               d.res = inf | ((ua.sgn ^ ub.sgn)
                        ? (q.lng ? `FLBE_SGN_L : `FLBE_SGN_S) : 64'h0);
            end else begin
               d.y  = y_fix;
               d.go = 1'h1;
               d.st = flbe_pkg::FLBE_ST_LOG;
            end
         end
         flbe_pkg::FLBE_ST_LOG: begin
            // log2(1+x) shares the sign of x, so the product sign
            // follows both operand signs
            if (lg.done) begin
               d.sgn = ua.sgn ^ ub.sgn;
               d.mag = 128'(lmag) * 128'(ub.m);
               d.e   = 14'(int'(ub.e) - `FLBE_LOG_FB);
               d.flags[`FLBE_F_INX] = 1'h1;  // Transcendental result
               d.st  = flbe_pkg::FLBE_ST_PACK;
            end
         end
         flbe_pkg::FLBE_ST_PACK: begin
            d.res = pk[63:0];
            d.flags[`FLBE_F_OVF] = pk[65];
            d.flags[`FLBE_F_INX] = q.flags[`FLBE_F_INX] | pk[64];
            d.flags[`FLBE_F_UNF] = pk[66]
                     && (pk[64] || q.flags[`FLBE_F_INX]);
            d.st  = flbe_pkg::FLBE_ST_DONE;
         end
         flbe_pkg::FLBE_ST_DONE: begin
            d.st = flbe_pkg::FLBE_ST_IDLE;
         end
         default: begin
            d.st = flbe_pkg::FLBE_ST_IDLE;
         end
      endcase
      // Masked exceptions are only recorded
      if (d.st == flbe_pkg::FLBE_ST_DONE
          && q.st != flbe_pkg::FLBE_ST_DONE) begin
         d.fault = |(d.flags & ~ac_mask_i);
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q    <= '0;
         q.st <= flbe_pkg::FLBE_ST_IDLE;
      end else begin
         q <= d;
      end
   end

   assign ur          = unpack(q.res, q.lng);
   assign busy_o      = q.st != flbe_pkg::FLBE_ST_IDLE;
   assign done_o      = q.st == flbe_pkg::FLBE_ST_DONE;
   assign res_o       = q.res;
   assign flags_o     = q.flags;
   assign fault_o     = q.fault;
   assign rsv_fault_o = q.rsv;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   done_latency_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (!busy_o && start_i) |-> ##[2:63] done_o)
      else $error("result not delivered in time");
   logb_exact_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o && !is_ep && !rsv_fault_o && !ua.nan && !ua.inf
      && !ua.zero |-> flags_o == 5'h00 && !ur.nan)
      else $error("binary-log result not exact");
   logb_denorm_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o && !is_ep && ua.den && !rsv_fault_o
      |-> res_o > (q.lng ? `FLBE_LOGB_MIN_L : `FLBE_LOGB_MIN_S))
      else $error("denormal exponent clamped");
   logb_zdiv_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o && !is_ep && ua.zero && !rsv_fault_o
      |-> flags_o[`FLBE_F_ZDV] && ur.inf && ur.sgn)
      else $error("zero source missed zero-divide");
   rsv_encode_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      q.st == flbe_pkg::FLBE_ST_PREP && ac_norm_mode_i && ua.den
      |=> done_o && rsv_fault_o)
      else $error("reserved encoding not faulted");
   fault_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(done_o) && $past(q.st) == flbe_pkg::FLBE_ST_PACK
      |-> fault_o == |(flags_o & ~$past(ac_mask_i)))
      else $error("fault not gated by mask");
   snan_inv_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o && !rsv_fault_o && ua.snan
      |-> flags_o[`FLBE_F_INV] && ur.nan)
      else $error("signaling NaN not invalid");
   unf_inexact_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o && flags_o[`FLBE_F_UNF] |-> flags_o[`FLBE_F_INX])
      else $error("underflow without inexact");
   ep_inf_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o && is_ep && !rsv_fault_o && ua.zero && ub.inf
      |-> flags_o[`FLBE_F_INV] && ur.nan)
      else $error("zero times infinity not invalid");
   ep_range_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o && is_ep && !rsv_fault_o && !ub.nan && a_big
      |-> flags_o[`FLBE_F_INV])
      else $error("out of range src1 not invalid");
   qnan_res_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o && !rsv_fault_o && (ua.nan || (is_ep && ub.nan))
      |-> ur.nan)
      else $error("NaN operand gave non-NaN");

endmodule : flbe_unit

// ==== tb/flbe_issue_model.sv ====
// Purpose : Issue side register file feeding long operands
// Assumes : Written by the bench one word at a time
// Notes   : Long values are read as an even/odd register pair
`timescale 1ns/1ps

module flbe_issue_model (
   input  wire logic        clk_i,  // Clock
   input  wire logic        wr_i,   // Register write
   input  wire logic [3:0]  wa_i,   // Write index
   input  wire logic [31:0] wd_i,   // Write data
   input  wire logic [3:0]  ra_i,   // Pair index
   output logic      [63:0] pair_o  // Odd register high, even low
);
   logic [31:0] gr [16];

   // Word writes from the bench
   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         gr[wa_i] <= wd_i;
      end
   end

   // Low index bit dropped: an odd name would split the value
   assign pair_o = {gr[{ra_i[3:1], 1'h1}],
                    gr[{ra_i[3:1], 1'h0}]};
endmodule : flbe_issue_model

// ==== tb/testbench.sv ====
// Purpose : Self-checking bench for the log datapath
// Assumes : Inputs change on the falling edge
// Notes   : Single results checked in the low word
`timescale 1ns/1ps

module testbench;
   logic        clk, arst_n, start, op, lng, nm, busy, done;
   logic        fault, rsv, wr, use_pair;
   logic [63:0] s1, s2, res, pair;
   logic [4:0]  mask, flags;
   logic [3:0]  wa, ra;
   logic [31:0] wd;
   int          error_cnt = 0;
   int          checks = 0;

   flbe_unit dut (.clk_i(clk), .arst_n_i(arst_n), .start_i(start),
      .op_i(op), .long_i(lng), .src1_i(use_pair ? pair : s1),
      .src2_i(s2), .ac_mask_i(mask), .ac_norm_mode_i(nm),
      .busy_o(busy), .done_o(done), .res_o(res), .flags_o(flags),
      .fault_o(fault), .rsv_fault_o(rsv));
   flbe_issue_model partner (.clk_i(clk), .wr_i(wr), .wa_i(wa),
      .wd_i(wd), .ra_i(ra), .pair_o(pair));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task chk(input string what, input logic [63:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task end_of_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   // One issue; poke retries start while busy, which must be ignored
   task run(input logic o, l, input logic [63:0] a, b,
            input int lat, input logic poke);
      int n;
      n = 0;
      @(negedge clk);
      op = o; lng = l; s1 = a; s2 = b; start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      while (done !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
         start = poke && n == 1;
         if (poke) s1 = 64'h3F000000;
      end
      start = 1'b0;
      // n counts falling edges after the taking edge, one short of it
      chk("latency", 64'(n + 1), 64'(lat));
      @(negedge clk);
      chk("pulse", {busy, done}, 64'h0);
   endtask : run

   // Result within one unit of the last place
   task near(input logic [63:0] exp);
      chk("res", (res + 1 >= exp && res <= exp + 1) ? exp : res, exp);
   endtask : near

   task t_logb;
      run(0, 0, 64'h41000000, 0, 3, 0);
      chk("res", res, 64'h40400000);
      run(0, 0, 64'h00000001, 0, 3, 0);
      chk("res", res, 64'hC3150000);
      chk("flags", flags, 64'h00);
      wr = 1'b1; wa = 4'h4; wd = 32'h0;
      @(negedge clk);
      wa = 4'h5; wd = 32'h40200000;
      @(negedge clk);
      wr = 1'b0; ra = 4'h4; use_pair = 1'b1;
      run(0, 1, 0, 0, 3, 0);
      use_pair = 1'b0;
      chk("res", res, 64'h4008000000000000);
   endtask : t_logb

   task t_zero;
      run(0, 0, 64'h80000000, 0, 2, 0);
      chk("res", res, 64'hFF800000);
      chk("flags", flags, 64'h08);
      chk("fault", fault, 64'h0);
      mask = 5'h17;
      run(0, 0, 0, 0, 2, 0);
      chk("fault", fault, 64'h1);
      nm = 1'b1;
      run(0, 0, 64'h00000001, 0, 2, 0);
      chk("rsv", {rsv, flags}, 64'h20);
      chk("res", res, 64'hFF800000);
      nm = 1'b0; mask = 5'h1F;
   endtask : t_zero

   task t_nan;
      for (int i = 0; i < 3; i++) begin
         mask = 5'h1B;
         run(i > 0, 0, i < 2 ? 64'h7F800001 : 0,
             i == 2 ? 64'h7F800001 : 64'h3F800000, 2, 0);
         chk("res", res, 64'h7FC00000);
         chk("flags", {fault, flags}, 64'h24);
         mask = 5'h1F;
         run(i > 0, 0, 64'h7FC00000, 64'h3F800000, 2, 0);
         chk("qnan", {fault, flags, res[31:0]}, 64'h7FC00000);
      end
   endtask : t_nan

   task t_logep;
      run(1, 0, 0, 64'h7F800000, 2, 0);
      chk("flags", flags, 64'h04);
      run(1, 0, 64'h3F800000, 64'h3F800000, 2, 0);
      chk("flags", flags, 64'h04);
      run(1, 0, 0, 64'hC0000000, 2, 0);
      chk("res", res, 64'h80000000);
      run(1, 0, 64'h3E800000, 64'h3F800000, 63, 1);
      near(64'h3EA4D3C2);
      chk("flags", flags, 64'h10);
      // Smallest normal src2 scales log2(1.25) into the denormal range
      run(1, 0, 64'h3E800000, 64'h00800000, 63, 0);
      near(64'h002934F1);
      chk("flags", flags, 64'h12);
   endtask : t_logep

   // Main sequence: two cycles of reset, then the scenarios
   initial begin
      arst_n = 1'b0; start = 1'b0; op = 1'b0; lng = 1'b0; nm = 1'b0;
      s1 = 0; s2 = 0; mask = 5'h1F; wr = 1'b0; wa = 0; wd = 0;
      ra = 0; use_pair = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk("idle", {busy, done, fault, rsv, flags, res[31:0]}, 64'h0);
      t_logb();
      t_zero();
      t_nan();
      t_logep();
      end_of_test();
   end

   // Scenarios need about 200 cycles
   initial begin
      #200000;
      error_cnt++;
      end_of_test();
   end
endmodule : testbench
